// [src/scc_pkg.sv]
// types shared by the serial port modules
package scc_pkg;
  typedef logic [3:0] scc_addr_t;
  typedef logic [15:0] scc_word_t;
  typedef enum logic [1:0] {
    SCC_PH_IDLE = 2'b00,
    SCC_PH_FIRST = 2'b01,
    SCC_PH_SECOND = 2'b10
  } scc_phase_t;
  typedef struct packed {
    logic [15:0] tx;
    logic [15:0] rx;
  } scc_shift_t;
  typedef struct packed {
    logic [12:0] con;
    logic en;
    logic [15:0] txbuf;
    logic tbf;
    logic [15:0] rxbuf;
    logic rbf;
    logic rov;
    scc_phase_t phase;
    logic [9:0] cnt;
    logic [4:0] bitcnt;
    logic deliver;
    logic sck_s1;
    logic sck_s2;
    logic sck_prev;
    logic sdi_s1;
    logic sdi_s2;
    logic ss_s1;
    logic ss_s2;
    logic [15:0] rdata;
    logic sck_o;
    logic sck_oe_n;
    logic sdo_o;
    logic sdo_oe_n;
  } scc_state_t;
endpackage

// [src/scc_regs.svh]
// register offsets, field positions, reset values and counts of the serial port
`ifndef SCC_REGS_SVH
`define SCC_REGS_SVH
`define SCC_ADDR_CON1 4'h0
`define SCC_ADDR_BUF 4'h1
`define SCC_ADDR_STAT 4'h2
`define SCC_CLK_OUT_DIS_BIT 12
`define SCC_DAT_OUT_DIS_BIT 11
`define SCC_WORD_SEL_BIT 10
`define SCC_SAMPLE_PH_BIT 9
`define SCC_EDGE_SEL_BIT 8
`define SCC_SS_EN_BIT 7
`define SCC_POL_BIT 6
`define SCC_MASTER_BIT 5
`define SCC_SEC_PRE_LSB 2
`define SCC_PRI_PRE_LSB 0
`define SCC_CON_RESET 13'h0000
`define SCC_EN_BIT 15
`define SCC_OVF_BIT 6
`define SCC_TBF_BIT 1
`define SCC_RBF_BIT 0
`define SCC_BYTE_BITS 5'h08
`define SCC_WORD_BITS 5'h10
`endif

// [src/scc_shift.sv]
// transmit and receive shift registers of the serial port
`timescale 1ns/1ps
`default_nettype none
module scc_shift #(
  parameter int DATA_W = 16
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic i_load,
  input wire scc_pkg::scc_word_t i_load_data,
  input wire logic i_shift,
  input wire logic i_sample,
  input wire logic i_sample_bit,
  input wire logic i_word_width_select,
  output logic o_tx_bit,
  output scc_pkg::scc_word_t o_rx_word
);
  import scc_pkg::*;
  scc_shift_t st_r;
  scc_shift_t st_nxt;

  if (DATA_W != 16) begin : g_chk
    $error("scc_shift serves only a 16-bit shift path");
  end

  always_comb begin
    st_nxt = st_r;
    if (i_load) begin
      st_nxt.tx = i_load_data;
    end else if (i_shift) begin
      st_nxt.tx = {st_r.tx[14:0], 1'b0};
    end
    if (i_sample) begin
      st_nxt.rx = {st_r.rx[14:0], i_sample_bit};
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      st_r <= '0;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  // msb of the active width leads on the wire
  assign o_tx_bit = i_word_width_select ? st_r.tx[15] : st_r.tx[7];
  assign o_rx_word = i_word_width_select ? st_r.rx : {8'h00, st_r.rx[7:0]};
endmodule
`default_nettype wire

// [src/scc_top.sv]
// serial port with first control register, buffers and pin control
//
// Contract
// R1 - master with clock output disabled releases clock pin to general I/O
// R2 - clock output enabled: master drives its internal serial clock on the pin
// R3 - data output disabled: data pin not driven, left to general I/O
// R4 - data output enabled: port drives data pin and shifts transmit data
// R5 - word width set: each transfer shifts 16 bits
// R6 - word width clear: each transfer shifts 8 bits
// R7 - master, sample phase set: input captured at end of bit time
// R8 - master, sample phase clear: input captured at middle of bit time
// R9 - edge select set: data changes active-to-idle; clear: idle-to-active
// R10 - polarity set: clock idles high; clear: clock idles low
// R11 - control bits 15..13 read zero, writes ignored
// R12 - reset clears all control bits: byte transfers, outputs enabled
`timescale 1ns/1ps
`default_nettype none
`include "scc_regs.svh"
module scc_top #(
  parameter int DATA_W = 16
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire scc_pkg::scc_addr_t i_addr,
  input wire scc_pkg::scc_word_t i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output scc_pkg::scc_word_t o_rdata,
  input wire logic i_sck,
  output logic o_sck,
  output logic o_sck_oe_n,
  input wire logic i_sdi,
  output logic o_sdo,
  output logic o_sdo_oe_n,
  input wire logic i_ss_n
);
  import scc_pkg::*;
  scc_state_t st_r;
  scc_state_t st_nxt;
  logic load_w;
  logic shift_w;
  logic sample_w;
  logic done_w;
  logic tx_bit;
  scc_word_t rx_word;
  scc_word_t stat_word;
  logic [9:0] half_len;
  logic [4:0] width;
  logic master;
  logic cke;
  logic cpol;
  logic input_sample_phase;
  logic lead;
  logic trail;
  logic selected;

  if (DATA_W != 16) begin : g_chk
    $error("scc_top serves only a 16-bit data path");
  end

  // divider product spans 1..512, so ten bits hold it
  function automatic logic [9:0] f_half_len(input logic [1:0] pri, input logic [2:0] sec);
    logic [9:0] p;
    p = 10'h001 << {pri ^ 2'b11, 1'b0};
    return 10'((p * (10'h008 - {7'h00, sec})));
  endfunction

  assign master = st_r.con[`SCC_MASTER_BIT];
  assign cke = st_r.con[`SCC_EDGE_SEL_BIT];
  assign cpol = st_r.con[`SCC_POL_BIT];
  assign input_sample_phase = st_r.con[`SCC_SAMPLE_PH_BIT];
  assign width = st_r.con[`SCC_WORD_SEL_BIT] ? `SCC_WORD_BITS : `SCC_BYTE_BITS; // R5 R6
  assign half_len = f_half_len(st_r.con[`SCC_PRI_PRE_LSB +: 2], st_r.con[`SCC_SEC_PRE_LSB +: 3]);
  // slave edges come from the twice-synchronised clock only
  assign lead = (st_r.sck_prev == cpol) && (st_r.sck_s2 != cpol);
  assign trail = (st_r.sck_prev != cpol) && (st_r.sck_s2 == cpol);
  assign selected = st_r.en && !master && (!st_r.con[`SCC_SS_EN_BIT] || !st_r.ss_s2);

  always_comb begin
    stat_word = 16'h0000;
    stat_word[`SCC_EN_BIT] = st_r.en;
    stat_word[`SCC_OVF_BIT] = st_r.rov;
    stat_word[`SCC_TBF_BIT] = st_r.tbf;
    stat_word[`SCC_RBF_BIT] = st_r.rbf;
  end

  always_comb begin
    st_nxt = st_r;
    load_w = 1'b0;
    shift_w = 1'b0;
    sample_w = 1'b0;
    done_w = 1'b0;
    st_nxt.rdata = 16'h0000;
    st_nxt.sck_s1 = i_sck;
    st_nxt.sck_s2 = st_r.sck_s1;
    st_nxt.sck_prev = st_r.sck_s2;
    st_nxt.sdi_s1 = i_sdi;
    st_nxt.sdi_s2 = st_r.sdi_s1;
    st_nxt.ss_s1 = i_ss_n;
    st_nxt.ss_s2 = st_r.ss_s1;
    if (i_wr) begin
      case (i_addr)
        `SCC_ADDR_CON1: st_nxt.con = i_wdata[12:0]; // R11
        `SCC_ADDR_BUF: begin
          st_nxt.txbuf = i_wdata;
          st_nxt.tbf = 1'b1;
        end
        `SCC_ADDR_STAT: begin
          st_nxt.en = i_wdata[`SCC_EN_BIT];
          if (!i_wdata[`SCC_OVF_BIT]) begin
            st_nxt.rov = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        `SCC_ADDR_CON1: st_nxt.rdata = {3'b000, st_r.con}; // R11
        `SCC_ADDR_BUF: begin
          st_nxt.rdata = st_r.rxbuf;
          st_nxt.rbf = 1'b0;
        end
        `SCC_ADDR_STAT: st_nxt.rdata = stat_word;
        default: st_nxt.rdata = 16'h0000;
      endcase
    end
    // master engine: two halves per bit, data set at the start of each bit
    case (st_r.phase)
      SCC_PH_IDLE: begin
        st_nxt.cnt = 10'h000;
        if (st_r.en && master && st_r.tbf) begin
          load_w = 1'b1;
          st_nxt.tbf = 1'b0;
          st_nxt.bitcnt = 5'h00;
          st_nxt.phase = SCC_PH_FIRST;
        end
      end
      SCC_PH_FIRST: begin
        if (!st_r.en || !master) begin
          st_nxt.phase = SCC_PH_IDLE;
        end else if (st_r.cnt == half_len - 10'h001) begin
          st_nxt.cnt = 10'h000;
          st_nxt.phase = SCC_PH_SECOND;
          sample_w = !input_sample_phase; // R8
        end else begin
          st_nxt.cnt = st_r.cnt + 10'h001;
        end
      end
      SCC_PH_SECOND: begin
        if (!st_r.en || !master) begin
          st_nxt.phase = SCC_PH_IDLE;
        end else if (st_r.cnt == half_len - 10'h001) begin
          st_nxt.cnt = 10'h000;
          sample_w = input_sample_phase; // R7
          if (st_r.bitcnt == width - 5'h01) begin // R5 R6
            done_w = 1'b1;
            st_nxt.phase = SCC_PH_IDLE;
          end else begin
            shift_w = 1'b1;
            st_nxt.bitcnt = st_r.bitcnt + 5'h01;
            st_nxt.phase = SCC_PH_FIRST;
          end
        end else begin
          st_nxt.cnt = st_r.cnt + 10'h001;
        end
      end
      default: st_nxt.phase = SCC_PH_IDLE;
    endcase
    // slave engine follows the sampled peer clock
    if (!master) begin
      if (!selected) begin
        st_nxt.bitcnt = 5'h00;
      end else if (cke ? lead : trail) begin
        sample_w = 1'b1;
        if (st_r.bitcnt == width - 5'h01) begin // R5 R6
          done_w = 1'b1;
          st_nxt.bitcnt = 5'h00;
        end else begin
          st_nxt.bitcnt = st_r.bitcnt + 5'h01;
        end
      end else if (cke ? trail : (lead && st_r.bitcnt != 5'h00)) begin
        shift_w = 1'b1; // R9
      end else if (st_r.tbf && st_r.bitcnt == 5'h00 && st_r.en) begin
        load_w = 1'b1;
        st_nxt.tbf = 1'b0;
      end
    end
    // a buffer write in the cycle of a load wins, so the new word stays pending
    if (i_wr && i_addr == `SCC_ADDR_BUF) begin
      st_nxt.tbf = 1'b1;
    end
    // received word lands a cycle after done_w closes its frame
    st_nxt.deliver = done_w;
    if (st_r.deliver) begin
      if (st_r.rbf) begin
        st_nxt.rov = 1'b1;
      end else begin
        st_nxt.rxbuf = rx_word;
        st_nxt.rbf = 1'b1;
      end
    end
    // pins follow the current state one cycle later, clock and data alike
    if (st_r.phase == SCC_PH_FIRST) begin
      st_nxt.sck_o = cke ? cpol : !cpol; // R9 R10
    end else if (st_r.phase == SCC_PH_SECOND) begin
      st_nxt.sck_o = cke ? !cpol : cpol; // R9 R10
    end else begin
      st_nxt.sck_o = cpol; // R10
    end
    st_nxt.sck_oe_n = !(st_r.en && master && !st_r.con[`SCC_CLK_OUT_DIS_BIT]); // R1 R2
    st_nxt.sdo_o = tx_bit; // R4
    st_nxt.sdo_oe_n = !(st_r.en && !st_r.con[`SCC_DAT_OUT_DIS_BIT]
                        && (master || selected)); // R3 R4
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      st_r <= '0;
      st_r.con <= `SCC_CON_RESET; // R12
      st_r.sck_oe_n <= 1'b1;
      st_r.sdo_oe_n <= 1'b1;
      st_r.phase <= SCC_PH_IDLE;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  scc_shift #(
    .DATA_W(DATA_W)
  ) u_shift (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_ce(i_ce),
    .i_load(load_w),
    .i_load_data(st_r.txbuf),
    .i_shift(shift_w),
    .i_sample(sample_w),
    .i_sample_bit(master ? st_r.sdi_s2 : st_r.sdi_s2),
    .i_word_width_select(st_r.con[`SCC_WORD_SEL_BIT]),
    .o_tx_bit(tx_bit),
    .o_rx_word(rx_word)
  );

  assign o_rdata = st_r.rdata;
  assign o_sck = st_r.sck_o;
  assign o_sck_oe_n = st_r.sck_oe_n;
  assign o_sdo = st_r.sdo_o;
  assign o_sdo_oe_n = st_r.sdo_oe_n;

  AST_CLK_RELEASE: assert property (@(posedge i_mclk) disable iff (i_reset) // R1
    i_ce && st_r.con[`SCC_CLK_OUT_DIS_BIT] |=> o_sck_oe_n)
    else $error("clock pin driven while clock output disabled");
  AST_CLK_DRIVE: assert property (@(posedge i_mclk) disable iff (i_reset) // R2
    i_ce && st_r.en && master && !st_r.con[`SCC_CLK_OUT_DIS_BIT] |=> !o_sck_oe_n)
    else $error("master clock pin not driven while enabled");
  AST_DATA_RELEASE: assert property (@(posedge i_mclk) disable iff (i_reset) // R3
    i_ce && st_r.con[`SCC_DAT_OUT_DIS_BIT] |=> o_sdo_oe_n)
    else $error("data pin driven while data output disabled");
  AST_DATA_DRIVE: assert property (@(posedge i_mclk) disable iff (i_reset) // R4
    i_ce && st_r.en && master && !st_r.con[`SCC_DAT_OUT_DIS_BIT] |=> !o_sdo_oe_n ##0 o_sdo == $past(tx_bit))
    else $error("master data pin not carrying transmit bit");
  AST_WORD_LEN: assert property (@(posedge i_mclk) disable iff (i_reset) // R5
    done_w && st_r.con[`SCC_WORD_SEL_BIT] |-> st_r.bitcnt == 5'h0F)
    else $error("word frame did not end after 16 bits");
  AST_BYTE_LEN: assert property (@(posedge i_mclk) disable iff (i_reset) // R6
    done_w && !st_r.con[`SCC_WORD_SEL_BIT] |-> st_r.bitcnt == 5'h07)
    else $error("byte frame did not end after 8 bits");
  AST_SAMPLE_END: assert property (@(posedge i_mclk) disable iff (i_reset) // R7
    sample_w && master && input_sample_phase |-> st_r.phase == SCC_PH_SECOND)
    else $error("late sample not at end of bit time");
  AST_SAMPLE_MID: assert property (@(posedge i_mclk) disable iff (i_reset) // R8
    sample_w && master && !input_sample_phase |-> st_r.phase == SCC_PH_FIRST)
    else $error("mid sample not at middle of bit time");
  AST_IDLE_LEVEL: assert property (@(posedge i_mclk) disable iff (i_reset) // R10
    i_ce && st_r.phase == SCC_PH_IDLE |=> o_sck == $past(cpol))
    else $error("idle clock level differs from polarity");
  AST_UPPER_ZERO: assert property (@(posedge i_mclk) disable iff (i_reset) // R11
    i_ce && i_rd && i_addr == `SCC_ADDR_CON1 |=> o_rdata[15:13] == 3'b000)
    else $error("unimplemented control bits read nonzero");
  AST_RESET_CLEAR: assert property (@(posedge i_mclk) // R12
    i_reset |=> st_r.con == 13'h0000 && o_sck_oe_n && o_sdo_oe_n)
    else $error("control bits not cleared by reset");
endmodule
`default_nettype wire

// [testbench/scc_peer.sv]
// behavioural serial peer answering the port's master frames
`timescale 1ns/1ps
`default_nettype none
module scc_peer (
  input wire logic i_sck_pin,
  input wire logic i_sdo_pin,
  input wire logic i_pol,
  input wire logic i_edge_sel,
  input wire logic i_wide,
  input wire logic i_sel,
  input wire logic [15:0] i_tx,
  output logic o_sdi,
  output logic [15:0] o_rx,
  output logic [5:0] o_edges
);
  logic [15:0] sh;
  logic [5:0] nsamp;
  logic out_bit;
  logic pin_q;
  // msb first; byte frames use the low byte only
  assign out_bit = i_wide ? sh[15] : sh[7];
  // deselected line shows the inverse of the reloaded word's leading bit, never a stale copy
  assign o_sdi = i_sel ? out_bit : ~out_bit;
  // one process owns all peer state; while deselected it reloads and clears
  always @(i_sck_pin or i_sel or i_tx) begin
    if (!i_sel) begin
      sh <= i_tx;
      o_rx <= 16'h0000;
      o_edges <= 6'h00;
      nsamp <= 6'h00;
    end else if (i_sck_pin !== pin_q && (i_sck_pin === 1'b0 || i_sck_pin === 1'b1)) begin
      o_edges <= o_edges + 6'h01;
      if ((i_sck_pin ^ i_pol) == i_edge_sel) begin
        o_rx <= {o_rx[14:0], i_sdo_pin};
        nsamp <= nsamp + 6'h01;
      end else if (nsamp != 6'h00) begin
        // first idle-to-active edge only opens the frame, so no shift there
        sh <= {sh[14:0], 1'b0};
      end
    end
    pin_q = i_sck_pin;
  end
endmodule
`default_nettype wire

// [testbench/spi_control_config_one_bench.sv]
// self-checking bench of the serial port configuration register
`timescale 1ns/1ps
`default_nettype none
`include "scc_regs.svh"
module spi_control_config_one_bench;
  import scc_pkg::*;
  logic i_mclk, i_reset, i_wr, i_rd, sel, pol, edge_sel, wide;
  scc_addr_t i_addr;
  scc_word_t i_wdata, o_rdata, tx, ptx, d, w, rx;
  logic o_sck, o_sck_oe_n, o_sdo, o_sdo_oe_n, sdi, sck_pin, sdo_pin;
  logic [5:0] edges, f;
  logic [5:0] cfg [6];
  int n_mismatch = 0;
  int checks_done = 0;
  // released pins are pulled up, so a silent pin reads 1
  assign sck_pin = o_sck_oe_n ? 1'b1 : o_sck;
  assign sdo_pin = o_sdo_oe_n ? 1'b1 : o_sdo;
  scc_top uut (.i_mclk(i_mclk), .i_reset(i_reset), .i_ce(1'b1), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sck(sck_pin),
    .o_sck(o_sck), .o_sck_oe_n(o_sck_oe_n), .i_sdi(sdi), .o_sdo(o_sdo),
    .o_sdo_oe_n(o_sdo_oe_n), .i_ss_n(1'b1));
  scc_peer peer (.i_sck_pin(sck_pin), .i_sdo_pin(sdo_pin), .i_pol(pol),
    .i_edge_sel(edge_sel), .i_wide(wide), .i_sel(sel), .i_tx(ptx), .o_sdi(sdi),
    .o_rx(rx), .o_edges(edges));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic wr(input scc_addr_t a, input scc_word_t v);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input scc_addr_t a, output scc_word_t v);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask
  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end
  // whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge i_mclk);
    n_mismatch++;
    test_done;
  end
  initial begin
    // {clk off, data off, word, sample phase, edge select, polarity}
    cfg = '{6'b000010, 6'b001101, 6'b001011, 6'b000100, 6'b010010, 6'b100010};
    i_reset = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 4'h0;
    i_wdata = 16'h0000;
    sel = 1'b0;
    pol = 1'b0;
    edge_sel = 1'b0;
    wide = 1'b0;
    ptx = 16'h0000;
    repeat (4) @(posedge i_mclk);
    i_reset <= 1'b0;
    rd(`SCC_ADDR_CON1, d);
    check(d, 16'h0000);
    check({14'h0000, o_sck_oe_n, o_sdo_oe_n}, 16'h0003);
    wr(`SCC_ADDR_CON1, 16'hFFFF);
    rd(`SCC_ADDR_CON1, d);
    check(d, 16'h1FFF);
    rd(4'h3, d);
    check(d, 16'h0000);
    wr(`SCC_ADDR_STAT, 16'h8000);
    // bit time is 8 clocks, 200 ns: primary 4:1, secondary 1:1
    for (int i = 0; i < 6; i++) begin
      f = cfg[i];
      w = f[3] ? 16'hFFFF : 16'h00FF;
      tx = 16'hA5C3 ^ {4{4'(i)}};
      ptx <= ~tx;
      pol <= f[0];
      edge_sel <= f[1];
      wide <= f[3];
      wr(`SCC_ADDR_CON1, {3'h0, f[5:2], f[1], 1'b0, f[0], 1'b1, 3'h7, 2'h2});
      rd(`SCC_ADDR_CON1, d);
      check(d, {3'h0, f[5:2], f[1], 1'b0, f[0], 1'b1, 3'h7, 2'h2});
      sel <= 1'b1;
      wr(`SCC_ADDR_BUF, tx);
      repeat (10) @(posedge i_mclk);
      check({15'h0000, o_sck_oe_n}, {15'h0000, f[5]});
      check({15'h0000, o_sdo_oe_n}, {15'h0000, f[4]});
      d = 16'h0000;
      for (int k = 0; k < 100 && d[`SCC_RBF_BIT] !== 1'b1; k++) rd(`SCC_ADDR_STAT, d);
      check({15'h0000, d[`SCC_RBF_BIT]}, 16'h0001);
      check({15'h0000, o_sck}, {15'h0000, f[0]});
      check({10'h000, edges}, f[5] ? 16'h0000 : (f[3] ? 16'h0020 : 16'h0010));
      if (!f[5]) begin
        check(rx & w, f[4] ? w : (tx & w));
        rd(`SCC_ADDR_BUF, d);
        check(d, ptx & w);
      end
      sel <= 1'b0;
    end
    test_done;
  end
endmodule
`default_nettype wire
